// ===== verilog/dcm_pkg.sv
package dcm_pkg;

    // Data path widths
    localparam int CODE_W = 14;
    localparam int NUM_CH = 8;
    localparam int ADDR_W = 5;
    localparam int CH_W   = 3;

    // Register addresses on the five-line parallel bus
    localparam logic [4:0] ADDR_CODE_BASE = 5'h00;  // 00..07 input codes
    localparam logic [4:0] ADDR_ZERO_BASE = 5'h08;  // 08..0F zero trims
    localparam logic [4:0] ADDR_GAIN_BASE = 5'h10;  // 10..17 gain trims
    localparam logic [4:0] ADDR_MONITOR   = 5'h18;
    localparam logic [4:0] ADDR_SPARE_PIN = 5'h19;
    localparam logic [4:0] ADDR_PENDING   = 5'h1A;

    // Reset values
    localparam logic [13:0] RST_CODE     = 14'h0000;
    localparam logic [13:0] RST_ZERO     = 14'h0000;
    localparam logic [13:0] RST_GAIN     = 14'h2000;
    localparam logic [13:0] RST_MONITOR  = 14'h0000;
    localparam logic [13:0] RST_SPARE    = 14'h2000;
    localparam logic [13:0] CODE_MAX     = 14'h3FFF;

    // Field positions
    localparam int MON_LSB     = 2;   // monitor select D13:D2
    localparam int MON_MSB     = 13;
    localparam int MON_W       = 12;
    localparam int MON_CH0     = 4;   // select index of channel 0 (D6)
    localparam int SPARE_BIT   = 13;  // pin bit D13
    localparam int PEND_LSB    = 6;   // channel 0 flag at D6

    // Correction time per channel
    localparam int CLK_PERIOD_NS = 40;
    localparam int CORR_TIME_NS  = 500;
    localparam int CORR_CYCLES   =
        (CORR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] CORR_LAST = 5'(CORR_CYCLES - 1);

    // Correction engine states
    typedef enum logic [0:0] {
        ENG_IDLE = 1'b0,
        ENG_RUN  = 1'b1
    } dcm_eng_t;

endpackage : dcm_pkg

// ===== verilog/dcm_regs.sv
// Summary of operation
// - Monitor select bits D13:D2 all zero: monitor off, output Hi-Z.
// - Non one-hot monitor value is stored but monitor output stays off.
// - D2 ref B, D3 ref A, D4 offset B, D5 offset A, D6-D13 channels 0-7.
// - Don't-care bits ignore writes and read back zero.
// - Channel input code is 14-bit unsigned, resets to zero.
// - Engine off: code goes to data register; on: held for correction.
// - Loading data register into latch changes that channel's output code.
// - Zero trim is 14-bit two's complement, one step per count, resets zero.
// - Gain trim straight binary, 0.5 to 1.5, 2000h is unity and reset.
// - Pin bit zero drives pin low, one releases it: open drain.
// - Reading pin bit returns the sampled pin level.
// - After reset pin bit is one, pin released, register reads 2000h.
// - Engine on: write to code, zero or gain sets channel pending flag.
// - Pending flag clears when corrected code reaches the data register.
// - Correction takes about 500 ns per channel.
// - Flag register: channel 7 at D13 down to channel 0 at D6.
// - All pending flags read zero while the engine is off.
// - Pending flag register is read-only and zero after reset.
// - Enable bit on: codes corrected by gain and zero; off: unchanged.
// - Busy summary is one while any channel pending, zero idle or off.
module dcm_regs (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // Parallel register port
    input  wire logic [4:0]             bus_addr,
    input  wire logic                   bus_wr,
    input  wire logic                   bus_rd,
    input  wire logic [13:0]            bus_wdata,
    output logic      [13:0]            bus_rdata_q,
    // Engine control and status
    input  wire logic                   calibration_engine_enable,
    output logic                        engine_busy_summary_q,
    // Output latch load and channel output codes
    input  wire logic                   load_latch,
    output logic      [7:0][13:0]       channel_code_bits_q,
    // Analog monitor routing
    output logic      [11:0]            monitor_route_q,
    output logic                        analog_monitor_output_oe_q,
    // Open-drain spare pin
    input  wire logic                   spare_pin_i,
    output logic                        spare_pin_o_q,
    output logic                        spare_pin_oe_q
);

    // Register storage
    logic [13:0]     code_q [dcm_pkg::NUM_CH];
    logic [13:0]     zero_q [dcm_pkg::NUM_CH];
    logic [13:0]     gain_q [dcm_pkg::NUM_CH];
    logic [13:0]     data_q [dcm_pkg::NUM_CH];
    logic [11:0]     mon_q;
    logic            spare_q;
    logic            pin_s_q;
    logic [7:0]      pending_q;
    logic [7:0]      pending_d;
    dcm_pkg::dcm_eng_t state_q;
    logic [2:0]      cur_ch_q;
    logic [4:0]      cnt_q;

    // Address decode
    wire [2:0]  a_ch       = bus_addr[2:0];
    wire        sel_code   = bus_addr[4:3] == dcm_pkg::ADDR_CODE_BASE[4:3];
    wire        sel_zero   = bus_addr[4:3] == dcm_pkg::ADDR_ZERO_BASE[4:3];
    wire        sel_gain   = bus_addr[4:3] == dcm_pkg::ADDR_GAIN_BASE[4:3];
    wire        sel_mon    = bus_addr == dcm_pkg::ADDR_MONITOR;
    wire        sel_spare  = bus_addr == dcm_pkg::ADDR_SPARE_PIN;
    wire        sel_pend   = bus_addr == dcm_pkg::ADDR_PENDING;
    wire        wr_code    = bus_wr && sel_code;
    wire        wr_zero    = bus_wr && sel_zero;
    wire        wr_gain    = bus_wr && sel_gain;
    wire        wr_chan    = wr_code || wr_zero || wr_gain;
    wire        eng_on     = calibration_engine_enable;

    // Flags raised by writes; write in the finishing cycle keeps flag set
    wire [7:0]  set_vec = (wr_chan && eng_on) ? 8'(1 << a_ch) : 8'h00;
    wire        finish  = state_q == dcm_pkg::ENG_RUN
                          && cnt_q == dcm_pkg::CORR_LAST;
    wire [7:0]  clr_vec = finish ? 8'(1 << cur_ch_q) : 8'h00;
    assign pending_d = eng_on ? ((pending_q & ~clr_vec) | set_vec)
                              : 8'h00;

    // Lowest pending channel is served first, one at a time
    logic [2:0] next_ch;
    always_comb begin
        next_ch = 3'h0;
        for (int i = dcm_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (pending_q[i]) begin
                next_ch = 3'(i);
            end
        end
    end

    // Correction arithmetic: code*(0.5 + g/16384) + zero, saturated
    wire [13:0]        c_code = code_q[cur_ch_q];
    wire [13:0]        c_gain = gain_q[cur_ch_q];
    wire [13:0]        c_zero = zero_q[cur_ch_q];
    wire [27:0]        c_prod = c_code * c_gain;
    wire signed [15:0] c_sum  = $signed({2'b00, 1'b0, c_code[13:1]})
                              + $signed({2'b00, c_prod[27:14]})
                              + $signed({{2{c_zero[13]}}, c_zero});
    wire [13:0] c_out = c_sum < 0 ? 14'h0000
                      : (c_sum > $signed({2'b00, dcm_pkg::CODE_MAX}))
                        ? dcm_pkg::CODE_MAX : c_sum[13:0];

    // Monitor select validity: exactly one bit set, all zero is not valid
    wire [11:0] mon_w     = bus_wdata[dcm_pkg::MON_MSB:dcm_pkg::MON_LSB];
    wire        mon_onehot = mon_q != 12'h000
                             && (mon_q & (mon_q - 12'h001)) == 12'h000;

    // Read data mux; unmapped addresses read zero
    logic [13:0] rd_mux;
    always_comb begin
        rd_mux = 14'h0000;
        if (sel_code) begin
            rd_mux = code_q[a_ch];
        end else if (sel_zero) begin
            rd_mux = zero_q[a_ch];
        end else if (sel_gain) begin
            rd_mux = gain_q[a_ch];
        end else if (sel_mon) begin
            rd_mux = {mon_q, 2'b00};
        end else if (sel_spare) begin
            rd_mux = {pin_s_q, 13'h0000};
        end else if (sel_pend) begin
            rd_mux = {pending_q, 6'h00};
        end
    end

    // Host-written channel registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < dcm_pkg::NUM_CH; i++) begin
                code_q[i] <= dcm_pkg::RST_CODE;
                zero_q[i] <= dcm_pkg::RST_ZERO;
                gain_q[i] <= dcm_pkg::RST_GAIN;
            end
        end else begin
            if (wr_code) begin
                code_q[a_ch] <= bus_wdata;
            end
            if (wr_zero) begin
                zero_q[a_ch] <= bus_wdata;
            end
            if (wr_gain) begin
                gain_q[a_ch] <= bus_wdata;
            end
        end
    end

    // Converter data registers: direct path or corrected result
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < dcm_pkg::NUM_CH; i++) begin
                data_q[i] <= dcm_pkg::RST_CODE;
            end
        end else if (!eng_on && wr_code) begin
            data_q[a_ch] <= bus_wdata;
        end else if (eng_on && finish) begin
            data_q[cur_ch_q] <= c_out;
        end
    end

    // Output latches follow data registers on load
    always_ff @(posedge clk) begin
        if (!rstn) begin
            channel_code_bits_q <= '0;
        end else if (load_latch) begin
            for (int i = 0; i < dcm_pkg::NUM_CH; i++) begin
                channel_code_bits_q[i] <= data_q[i];
            end
        end
    end

    // Correction engine sequencer; disable abandons work in progress
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q  <= dcm_pkg::ENG_IDLE;
            cur_ch_q <= 3'h0;
            cnt_q    <= 5'h00;
        end else begin
            case (state_q)
                dcm_pkg::ENG_IDLE: begin
                    cnt_q <= 5'h00;
                    if (eng_on && pending_q != 8'h00) begin
                        cur_ch_q <= next_ch;
                        state_q  <= dcm_pkg::ENG_RUN;
                    end
                end
                dcm_pkg::ENG_RUN: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (!eng_on || finish) begin
                        state_q <= dcm_pkg::ENG_IDLE;
                    end
                end
                default: begin
                    state_q <= dcm_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    // Pending flags and busy summary
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pending_q             <= 8'h00;
            engine_busy_summary_q <= 1'b0;
        end else begin
            pending_q             <= pending_d;
            engine_busy_summary_q <= |pending_d;
        end
    end

    // Monitor select storage; invalid codes kept as written
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mon_q <= dcm_pkg::RST_MONITOR[dcm_pkg::MON_MSB:dcm_pkg::MON_LSB];
        end else if (bus_wr && sel_mon) begin
            mon_q <= mon_w;
        end
    end

    // Monitor routing, one cycle behind the select register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            monitor_route_q            <= 12'h000;
            analog_monitor_output_oe_q <= 1'b0;
        end else begin
            monitor_route_q            <= mon_onehot ? mon_q : 12'h000;
            analog_monitor_output_oe_q <= mon_onehot;
        end
    end

    // Open-drain pin: only ever drives low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            spare_q        <= dcm_pkg::RST_SPARE[dcm_pkg::SPARE_BIT];
            spare_pin_o_q  <= 1'b0;
            spare_pin_oe_q <= 1'b0;
            pin_s_q        <= 1'b0;
        end else begin
            if (bus_wr && sel_spare) begin
                spare_q <= bus_wdata[dcm_pkg::SPARE_BIT];
            end
            spare_pin_o_q  <= 1'b0;
            spare_pin_oe_q <= ~spare_q;
            pin_s_q        <= spare_pin_i;
        end
    end

    // Registered read data, held between reads
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_rdata_q <= 14'h0000;
        end else if (bus_rd) begin
            bus_rdata_q <= rd_mux;
        end
    end

endmodule : dcm_regs

// ===== verification/dcm_regs_checker.sv
module dcm_regs_checker (
    // Clock, reset and register port
    input wire logic             clk,
    input wire logic             rstn,
    input wire logic [4:0]       bus_addr,
    input wire logic             bus_wr,
    input wire logic             bus_rd,
    input wire logic [13:0]      bus_wdata,
    input wire logic [13:0]      bus_rdata_q,
    // Engine and latches
    input wire logic             calibration_engine_enable,
    input wire logic             engine_busy_summary_q,
    input wire logic             load_latch,
    input wire logic [7:0][13:0] channel_code_bits_q,
    // Monitor and pin
    input wire logic [11:0]      monitor_route_q,
    input wire logic             analog_monitor_output_oe_q,
    input wire logic             spare_pin_i,
    input wire logic             spare_pin_o_q,
    input wire logic             spare_pin_oe_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Short decoded names
    wire logic en = calibration_engine_enable;
    wire logic bsy = engine_busy_summary_q;
    wire logic moe = analog_monitor_output_oe_q;
    wire logic mwr = bus_wr && bus_addr == dcm_pkg::ADDR_MONITOR;
    wire logic pwr = bus_wr && bus_addr == dcm_pkg::ADDR_SPARE_PIN;
    wire logic cwr = bus_wr && bus_addr < 5'h08;
    wire logic twr = bus_wr && bus_addr < 5'h18;
    // Monitor routing settles two edges after the write
    AST_MON_OFF:
    assert property (mwr && bus_wdata[13:2] == 12'h000 ##1 !mwr
        |=> !moe && monitor_route_q == 12'h000) else $error("monitor on");
    AST_MON_ONE:
    assert property (mwr && $onehot(bus_wdata[13:2]) ##1 !mwr
        |=> moe && monitor_route_q == $past(bus_wdata[13:2], 2))
        else $error("monitor route wrong");
    AST_MON_BAD:
    assert property (mwr && !$onehot0(bus_wdata[13:2]) ##1 !mwr |=> !moe)
        else $error("invalid monitor code drives output");
    // Open drain: only ever sinks, enable is the inverted bit
    AST_PIN_DRV:
    assert property (pwr ##1 !pwr
        |=> !spare_pin_o_q && spare_pin_oe_q == !$past(bus_wdata[13], 2))
        else $error("pin drive wrong");
    AST_PIN_READ:
    assert property (bus_rd && bus_addr == dcm_pkg::ADDR_SPARE_PIN
        && $stable(spare_pin_i) && $past(rstn)
        |=> bus_rdata_q == {$past(spare_pin_i), 13'h0000})
        else $error("pin read wrong");
    AST_BUSY_OFF:
    assert property (!en |=> !bsy) else $error("busy with engine off");
    AST_PEND_SET:
    assert property (en && twr |=> bsy) else $error("write did not pend");
    // Idle engine: one channel takes exactly fourteen busy cycles
    AST_CORR_TIME:
    assert property (en && twr && !bsy ##1 (en && !bus_wr)[*8]
        ##1 (en && !bus_wr)[*5] |=> bsy ##1 !bsy)
        else $error("correction time wrong");
    AST_LATCH:
    assert property (!en && cwr ##1 !en && !bus_wr
        ##1 !en && load_latch && !bus_wr
        |=> channel_code_bits_q[$past(bus_addr[2:0], 3)]
            == $past(bus_wdata, 3)) else $error("latch wrong");
    // Main scenarios reached
    cover property (mwr ##2 moe);
    cover property ($fell(bsy));
    cover property (spare_pin_oe_q);
endmodule : dcm_regs_checker

bind dcm_regs dcm_regs_checker i_chk (.clk, .rstn, .bus_addr, .bus_wr,
    .bus_rd, .bus_wdata, .bus_rdata_q, .calibration_engine_enable,
    .engine_busy_summary_q, .load_latch, .channel_code_bits_q,
    .monitor_route_q, .analog_monitor_output_oe_q, .spare_pin_i,
    .spare_pin_o_q, .spare_pin_oe_q);

// ===== verification/dcm_pin_partner.sv
module dcm_pin_partner (
    // Design side of the open-drain pin
    input wire logic drive_low,
    input wire logic drive_val,
    // Another device sharing the line
    input wire logic ext_low,
    // Resolved line level
    output logic     level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up wins unless a party sinks the line
    assign level = !((drive_low && !drive_val) || ext_low);
endmodule : dcm_pin_partner

// ===== verification/dcm_regs_bench.sv
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
$display("unexpected %s exp %h got %h", n, e, g); end end

module dcm_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rstn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    logic        ena = 1'b0, load_latch = 1'b0, ext_low = 1'b0;
    logic [4:0]  bus_addr = 5'h00;
    logic [13:0] bus_wdata = 14'h0000, bus_rdata_q, c, g, z;
    logic [7:0][13:0] codes;
    logic [11:0] route;
    logic        busy, mon_oe, pin_i, pin_o, pin_oe;
    int          fails = 0, compares = 0;

    always #20 clk = ~clk;

    dcm_regs i_dut (.clk, .rstn, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
        .bus_rdata_q, .calibration_engine_enable(ena),
        .engine_busy_summary_q(busy), .load_latch,
        .channel_code_bits_q(codes), .monitor_route_q(route),
        .analog_monitor_output_oe_q(mon_oe), .spare_pin_i(pin_i),
        .spare_pin_o_q(pin_o), .spare_pin_oe_q(pin_oe));
    dcm_pin_partner i_pin (.drive_low(pin_oe), .drive_val(pin_o),
        .ext_low(ext_low), .level(pin_i));

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // Bus cycles: strobe held one edge, dropped after it
    task automatic wr(input logic [4:0] a, input logic [13:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [13:0] e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1 `CHK("rdata", e, bus_rdata_q)
    endtask : rd_chk

    task automatic latch();
        @(posedge clk);
        load_latch <= 1'b1;
        @(posedge clk);
        load_latch <= 1'b0;
        #1;
    endtask : latch

    // Bounded wait for the engine to go idle
    task automatic wait_idle();
        int n;
        n = 0;
        #1;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 400) begin
            fails++;
            end_of_test();
        end
    endtask : wait_idle

    // Gain spans 0.5..1.5, zero is signed, result clamped
    function automatic logic [13:0] corr(logic [13:0] cd, gn, zr);
        int v;
        v = int'(cd >> 1) + int'((28'(cd) * 28'(gn)) >> 14);
        v = v + int'($signed(zr));
        return (v < 0) ? 14'h0000 : (v > 14'h3FFF) ? 14'h3FFF : 14'(v);
    endfunction : corr

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, unmapped reads zero
        for (int a = 0; a < 32; a++) begin
            c = (a >= 16 && a < 24 || a == 25) ? 14'h2000 : 14'h0000;
            rd_chk(5'(a), c);
        end
        // Engine off: codes go straight through to the latches
        for (int a = 0; a < 24; a++) wr(5'(a), 14'h2A5A ^ 14'(a));
        for (int a = 0; a < 24; a++) rd_chk(5'(a), 14'h2A5A ^ 14'(a));
        latch();
        for (int n = 0; n < 8; n++) begin
            `CHK("latch", 14'h2A5A ^ 14'(n), codes[n])
        end
        wr(dcm_pkg::ADDR_PENDING, 14'h3FFF);
        rd_chk(dcm_pkg::ADDR_PENDING, 14'h0000);
        // Every monitor source, then off and invalid codes
        for (int b = 0; b < 14; b++) begin
            z = (b < 12) ? 14'h0004 << b : 14'h3FFF * 14'(b - 12);
            wr(dcm_pkg::ADDR_MONITOR, z);
            repeat (2) @(posedge clk);
            #1 `CHK("route", (b < 12) ? 12'h001 << b : 12'h000, route)
            `CHK("mon_oe", b < 12, mon_oe)
        end
        rd_chk(dcm_pkg::ADDR_MONITOR, 14'h3FFC);
        // Spare pin sinks, releases, and reads the real line level
        wr(dcm_pkg::ADDR_SPARE_PIN, 14'h0000);
        repeat (2) @(posedge clk);
        #1 `CHK("pin_oe", 1'b1, pin_oe)
        rd_chk(dcm_pkg::ADDR_SPARE_PIN, 14'h0000);
        wr(dcm_pkg::ADDR_SPARE_PIN, 14'h3FFF);
        ext_low <= 1'b1;
        rd_chk(dcm_pkg::ADDR_SPARE_PIN, 14'h0000);
        ext_low <= 1'b0;
        rd_chk(dcm_pkg::ADDR_SPARE_PIN, 14'h2000);
        // Engine on: trims, flags, saturation on odd channels
        ena <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 14'h1000 : (i == 2) ? 14'h0010 : 14'h3FFF;
            g = (i == 1) ? 14'h3FFF : (i == 3) ? 14'h0000 : 14'h2000;
            z = (i == 0) ? 14'h0005 : (i == 1) ? 14'h1FFF
              : (i == 2) ? 14'h2000 : 14'h0000;
            wr(dcm_pkg::ADDR_GAIN_BASE + 5'(2 * i + 1), g);
            wr(dcm_pkg::ADDR_ZERO_BASE + 5'(2 * i + 1), z);
            wr(dcm_pkg::ADDR_CODE_BASE + 5'(2 * i + 1), c);
            rd_chk(dcm_pkg::ADDR_PENDING, 14'h0080 << (2 * i));
            wait_idle();
            rd_chk(dcm_pkg::ADDR_PENDING, 14'h0000);
            latch();
            `CHK("corr", corr(c, g, z), codes[2 * i + 1])
        end
        // Idle run, then engine switched off with the flag pending, before the run starts
        wr(dcm_pkg::ADDR_CODE_BASE, 14'h0123);
        wait_idle();
        wr(dcm_pkg::ADDR_CODE_BASE, 14'h0456);
        #1 `CHK("busy", 1'b1, busy)
        ena <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK("busy", 1'b0, busy)
        rd_chk(dcm_pkg::ADDR_PENDING, 14'h0000);
        // Load pulse two edges after the write, as the latch check expects
        wr(dcm_pkg::ADDR_CODE_BASE, 14'h0777);
        latch();
        `CHK("latch", 14'h0777, codes[0])
        end_of_test();
    end
endmodule : dcm_regs_bench
